// ---- logic/aew_map.svh ----
// register map, field positions, reset values and timing figures
// Operation
// - a set early_irq_on bit for inputs 0 to 31 lets that input's early_ready flag raise an interrupt; a clear bit suppresses it.
// - early_irq_on bits for inputs 32 to 43 sit in bits 11 to 0 of the high enable register, upper bits read zero.
// - hardware sets an input's early_ready flag on its early event; software only reads it and hardware clears it.
// - the early event timing follows each dedicated converter's own early_select, and the shared converter's own early_select.
// - early_ready flags for inputs 32 to 43 sit in bits 11 to 0 of the high status register, set whatever the high enable register holds.
// - one four-bit warm_count_code in bits 27 to 24 sets the warm-up length for all converters, each counting its own clock.
// - warm_count_code gives 2 to the power warm_exponent clocks: codes 0 to 4 give 16, 5 gives 32, up to 15 giving 32768.
// - warm_ready (bit 15 shared, bits 12 to 8 converters 4 to 0) sets once the warm-up count elapses after bias_power_on is set.
// - hardware clears a converter's warm_ready when software clears its bias_power_on.
// - with warm_irq_on set (bit 23 shared, bits 20 to 16 converters 4 to 0) a set warm_ready raises an interrupt.
// - bias_power_on (bit 7 shared, bits 4 to 0) powers the converter's analog and bias circuits and starts warm-up.
// - each calibration register (converters 1 to 4 and 7) takes writes only while its bias_power_on is clear.
// - two read-only input_present maps, loaded at boot, show inputs 0 to 31 and inputs 32 to 43.
// - early_select code 0 places the early event 1 converter clock before end of conversion, rising to 8 clocks for code 7.
`ifndef AEW_MAP_SVH
`define AEW_MAP_SVH

// byte offsets on the register bus
`define AEW_OFS_EARLY_EN_LO   8'h00
`define AEW_OFS_EARLY_EN_HI   8'h04
`define AEW_OFS_EARLY_ST_LO   8'h08
`define AEW_OFS_EARLY_ST_HI   8'h0C
`define AEW_OFS_WARMUP_CTRL   8'h10
`define AEW_OFS_CALIB_1       8'h14
`define AEW_OFS_CALIB_2       8'h18
`define AEW_OFS_CALIB_3       8'h1C
`define AEW_OFS_CALIB_4       8'h20
`define AEW_OFS_CALIB_7       8'h24
`define AEW_OFS_PRESENT_LO    8'h28
`define AEW_OFS_PRESENT_HI    8'h2C

// warmup_control field positions
`define AEW_WARM_CODE_LSB     24
`define AEW_WARM_IRQ7_BIT     23
`define AEW_WARM_IRQ_LSB      16
`define AEW_WARM_RDY7_BIT     15
`define AEW_WARM_RDY_LSB      8
`define AEW_BIAS7_BIT         7
`define AEW_BIAS_LSB          0

// counts and widths
`define AEW_NUM_INPUTS        44
`define AEW_NUM_HI_INPUTS     12
`define AEW_NUM_CONV          6
`define AEW_NUM_CALIB         5
`define AEW_WARM_MIN_EXP      4'h4
`define AEW_WARM_CNT_W        16

// reset values
`define AEW_RST_WORD          32'h0000_0000
`define AEW_RST_CODE          4'h0

`endif

// ---- logic/aew_pkg.sv ----
// shared types of the early-interrupt and warm-up control block
`default_nettype none
package aew_pkg;
  // one bit per converter: index 0..4 dedicated, index 5 shared
  typedef logic [5:0]  aew_conv_vec_t;
  // one bit per analog input 0..43
  typedef logic [43:0] aew_input_vec_t;
  typedef logic [3:0]  aew_code_t;
endpackage
`default_nettype wire

// ---- logic/aew_warm_if.sv ----
// carrier between register logic and the warm-up counters
`timescale 1ns/1ns
`default_nettype none
interface aew_warm_if;
  aew_pkg::aew_conv_vec_t bias_on;
  aew_pkg::aew_conv_vec_t tick;
  aew_pkg::aew_code_t     code;
  aew_pkg::aew_conv_vec_t ready;
  modport ctrl (output bias_on, output tick, output code, input ready);
  modport warm (input bias_on, input tick, input code, output ready);
endinterface
`default_nettype wire

// ---- logic/aew_warm.sv ----
// per-converter warm-up counters
`timescale 1ns/1ns
`default_nettype none
`include "aew_map.svh"
module aew_warm (
  input  wire logic pclk,
  input  wire logic presetn,
  aew_warm_if.warm  wif
);

  logic [`AEW_WARM_CNT_W-1:0] cnt_r   [`AEW_NUM_CONV];
  logic [`AEW_WARM_CNT_W-1:0] limit;
  aew_pkg::aew_conv_vec_t     ready_r;

  // codes below the floor all mean 16 clocks
  function automatic logic [3:0] warm_exponent(input logic [3:0] code);
    warm_exponent = (code < `AEW_WARM_MIN_EXP) ? `AEW_WARM_MIN_EXP : code;
  endfunction

  // last count value before warm-up completes; one shared code for all
  assign limit = `AEW_WARM_CNT_W'((32'd1 << warm_exponent(wif.code)) - 32'd1);

  // each converter counts its own clock ticks while biased
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= '0;
      for (int i = 0; i < `AEW_NUM_CONV; i++) begin
        cnt_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < `AEW_NUM_CONV; i++) begin
        if (!wif.bias_on[i]) begin
          cnt_r[i]   <= '0;    // restart on every power-up
          ready_r[i] <= 1'b0;
        end else if (!ready_r[i] && wif.tick[i]) begin
          if (cnt_r[i] >= limit) begin
            ready_r[i] <= 1'b1;
          end else begin
            cnt_r[i] <= cnt_r[i] + `AEW_WARM_CNT_W'(1);
          end
        end
      end
    end
  end

  assign wif.ready = ready_r;

endmodule // aew_warm
`default_nettype wire

// ---- logic/aew_ctrl.sv ----
// early-interrupt, warm-up and calibration register block on apb
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "aew_map.svh"
module aew_ctrl (
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // converter side, same clock domain
  input  wire logic [5:0]          conv_tick,
  input  wire logic [5:0]          conv_active,
  input  wire logic [5:0][3:0]     conv_clk_left,
  input  wire logic [5:0][5:0]     conv_input,
  input  wire logic [5:0][2:0]     early_select,
  input  wire logic [43:0]         early_clr,
  input  wire logic [43:0]         present_boot,
  output logic      [5:0]          bias_power_on,
  output logic      [4:0][31:0]    calib_word,
  output logic                     irq_early,
  output logic                     irq_warm
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  aew_pkg::aew_input_vec_t early_on_r;
  aew_pkg::aew_input_vec_t early_ready_r;
  aew_pkg::aew_input_vec_t early_evt;
  aew_pkg::aew_input_vec_t present_r;
  aew_pkg::aew_conv_vec_t  bias_r;
  aew_pkg::aew_conv_vec_t  warm_irq_on_r;
  aew_pkg::aew_conv_vec_t  warm_ready;
  aew_pkg::aew_code_t      warm_code_r;
  logic [31:0]             calib_r [`AEW_NUM_CALIB];
  logic                    boot_done_r;
  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic                    irq_early_r;
  logic                    irq_warm_r;

  // bus decode
  logic                    acc_start;
  logic                    wr_fire;
  logic                    rd_hit;
  logic [31:0]             rd_word;
  logic [31:0]             ctrl_word;

  aew_warm_if wif ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // early event lands when the converter is sel+1 clocks from the end
  function automatic logic early_hit(input logic [3:0] left,
                                     input logic [2:0] sel);
    early_hit = (left == ({1'b0, sel} + 4'd1));
  endfunction

  // calibration slot for an address, or 3'd7 when it is none
  function automatic logic [2:0] calib_slot(input logic [7:0] addr);
    case (addr)
      `AEW_OFS_CALIB_1: calib_slot = 3'd0;
      `AEW_OFS_CALIB_2: calib_slot = 3'd1;
      `AEW_OFS_CALIB_3: calib_slot = 3'd2;
      `AEW_OFS_CALIB_4: calib_slot = 3'd3;
      `AEW_OFS_CALIB_7: calib_slot = 3'd4;
      default:          calib_slot = 3'd7;
    endcase
  endfunction

  // calibration slot 0..3 belongs to converter 1..4, slot 4 to shared
  function automatic logic calib_locked(input logic [2:0] slot,
                                        input logic [5:0] bias);
    case (slot)
      3'd0:    calib_locked = bias[1];
      3'd1:    calib_locked = bias[2];
      3'd2:    calib_locked = bias[3];
      3'd3:    calib_locked = bias[4];
      3'd4:    calib_locked = bias[5];
      default: calib_locked = 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // apb handshake: one wait state, answer lands on the second edge
  // ---------------------------------------------------------------
  assign acc_start = psel && penable && !pready_r;
  assign wr_fire   = psel && penable && pready_r && pwrite;

  // read mux over the whole map; unmapped offsets are flagged
  always_comb begin
    rd_word = `AEW_RST_WORD;
    rd_hit  = 1'b1;
    case (paddr)
      `AEW_OFS_EARLY_EN_LO: rd_word = early_on_r[31:0];
      `AEW_OFS_EARLY_EN_HI: rd_word = {20'h0_0000, early_on_r[43:32]};
      `AEW_OFS_EARLY_ST_LO: rd_word = early_ready_r[31:0];
      `AEW_OFS_EARLY_ST_HI:
        rd_word = {20'h0_0000, early_ready_r[43:32]};
      `AEW_OFS_WARMUP_CTRL: rd_word = ctrl_word;
      `AEW_OFS_CALIB_1:     rd_word = calib_r[0];
      `AEW_OFS_CALIB_2:     rd_word = calib_r[1];
      `AEW_OFS_CALIB_3:     rd_word = calib_r[2];
      `AEW_OFS_CALIB_4:     rd_word = calib_r[3];
      `AEW_OFS_CALIB_7:     rd_word = calib_r[4];
      `AEW_OFS_PRESENT_LO:  rd_word = present_r[31:0];
      `AEW_OFS_PRESENT_HI:  rd_word = {20'h0_0000, present_r[43:32]};
      default:              rd_hit  = 1'b0;
    endcase
  end

  // warmup_control as software sees it; gaps read as zero
  always_comb begin
    ctrl_word = `AEW_RST_WORD;
    ctrl_word[`AEW_WARM_CODE_LSB +: 4]  = warm_code_r;
    ctrl_word[`AEW_WARM_IRQ7_BIT]       = warm_irq_on_r[5];
    ctrl_word[`AEW_WARM_IRQ_LSB +: 5]   = warm_irq_on_r[4:0];
    ctrl_word[`AEW_WARM_RDY7_BIT]       = warm_ready[5];
    ctrl_word[`AEW_WARM_RDY_LSB +: 5]   = warm_ready[4:0];
    ctrl_word[`AEW_BIAS7_BIT]           = bias_r[5];
    ctrl_word[`AEW_BIAS_LSB +: 5]       = bias_r[4:0];
  end

  // ready, read data and error are all registered to keep outputs clean
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= `AEW_RST_WORD;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= acc_start;
      if (acc_start) begin
        prdata_r  <= pwrite ? `AEW_RST_WORD : rd_word;
        pslverr_r <= !rd_hit;
      end else begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // early-interrupt enables
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_on_r <= '0;
    end else if (wr_fire) begin
      if (paddr == `AEW_OFS_EARLY_EN_LO) begin
        early_on_r[31:0] <= pwdata;
      end
      if (paddr == `AEW_OFS_EARLY_EN_HI) begin
        early_on_r[43:32] <= pwdata[11:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // early events: each converter's own select decides the moment
  // ---------------------------------------------------------------
  always_comb begin
    early_evt = '0;
    for (int c = 0; c < `AEW_NUM_CONV; c++) begin
      // index 5 carries the shared converter's select, the rest their own
      if (conv_active[c] && conv_tick[c] &&
          early_hit(conv_clk_left[c], early_select[c]) &&
          (conv_input[c] < 6'(`AEW_NUM_INPUTS))) begin
        early_evt[conv_input[c]] = 1'b1;
      end
    end
  end

  // flags are hardware set and hardware cleared; a set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_ready_r <= '0;
    end else begin
      early_ready_r <= (early_ready_r & ~early_clr) | early_evt;
    end
  end

  // ---------------------------------------------------------------
  // warm-up control fields
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_code_r   <= `AEW_RST_CODE;
      warm_irq_on_r <= '0;
      bias_r        <= '0;
    end else if (wr_fire && paddr == `AEW_OFS_WARMUP_CTRL) begin
      warm_code_r        <= pwdata[`AEW_WARM_CODE_LSB +: 4];
      warm_irq_on_r[5]   <= pwdata[`AEW_WARM_IRQ7_BIT];
      warm_irq_on_r[4:0] <= pwdata[`AEW_WARM_IRQ_LSB +: 5];
      bias_r[5]          <= pwdata[`AEW_BIAS7_BIT];
      bias_r[4:0]        <= pwdata[`AEW_BIAS_LSB +: 5];
    end
  end

  // counters see bias straight from the register so warm-up starts at once
  assign wif.bias_on = bias_r;
  assign wif.tick    = conv_tick;
  assign wif.code    = warm_code_r;
  assign warm_ready  = wif.ready;

  aew_warm u_warm (
    .pclk    (pclk),
    .presetn (presetn),
    .wif     (wif.warm)
  );

  // ---------------------------------------------------------------
  // calibration words: frozen while their converter is powered
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `AEW_NUM_CALIB; i++) begin
        calib_r[i] <= `AEW_RST_WORD;
      end
    end else if (wr_fire && calib_slot(paddr) != 3'd7) begin
      // a locked write completes on the bus but leaves the word alone
      if (!calib_locked(calib_slot(paddr), bias_r)) begin
        calib_r[calib_slot(paddr)] <= pwdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // input_present maps: caught once, on the first edge after reset
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_r   <= '0;
      boot_done_r <= 1'b0;
    end else if (!boot_done_r) begin
      present_r   <= present_boot;
      boot_done_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // interrupt requests: level while any enabled flag stands
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_early_r <= 1'b0;
      irq_warm_r  <= 1'b0;
    end else begin
      irq_early_r <= |(early_ready_r[31:0] & early_on_r[31:0]) ||
                     |(early_ready_r[43:32] & early_on_r[43:32]);
      irq_warm_r  <= |(warm_ready & warm_irq_on_r);
    end
  end

  // calibration words face the converters directly
  always_comb begin
    for (int i = 0; i < `AEW_NUM_CALIB; i++) begin
      calib_word[i] = calib_r[i];
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign bias_power_on = bias_r;
  assign irq_early     = irq_early_r;
  assign irq_warm      = irq_warm_r;

endmodule // aew_ctrl
`default_nettype wire

// ---- test/aew_ctrl_asserts.sv ----
// concurrent checks on the ports of the early-irq and warm-up block
`timescale 1ns/1ns
`default_nettype none
module aew_ctrl_asserts (
  input wire logic             pclk,
  input wire logic             presetn,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [5:0]       conv_tick,
  input wire logic [5:0]       conv_active,
  input wire logic [5:0][3:0]  conv_clk_left,
  input wire logic [5:0][5:0]  conv_input,
  input wire logic [5:0][2:0]  early_select,
  input wire logic [43:0]      early_clr,
  input wire logic [43:0]      present_boot,
  input wire logic [5:0]       bias_power_on,
  input wire logic [4:0][31:0] calib_word,
  input wire logic             irq_early,
  input wire logic             irq_warm
);
  logic [43:0] en_sh_r;
  logic        hit;
  wire logic   wr_done = psel && penable && pready && pwrite;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // shadow of the enables, so the irq can be predicted from the bus alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_sh_r <= 44'h000_0000_0000;
    end else if (wr_done && paddr == 8'h00) begin
      en_sh_r[31:0] <= pwdata;
    end else if (wr_done && paddr == 8'h04) begin
      en_sh_r[43:32] <= pwdata[11:0];
    end
  end

  // any converter reaching its early point on an enabled input
  always_comb begin
    hit = 1'b0;
    for (int c = 0; c < 6; c++) begin
      if (conv_active[c] && conv_tick[c] && conv_input[c] < 6'h2c &&
          conv_clk_left[c] == {1'b0, early_select[c]} + 4'h1 &&
          en_sh_r[conv_input[c]]) begin
        hit = 1'b1;
      end
    end
  end

  property p_early_irq;
    hit |-> ##2 irq_early;
  endproperty
  a_early_irq: assert property (p_early_irq)
    else $error("enabled early event gave no irq");
  property p_early_quiet;
    (en_sh_r == 44'h000_0000_0000) [*2] |-> !irq_early;
  endproperty
  a_early_quiet: assert property (p_early_quiet)
    else $error("early irq with every enable clear");
  property p_warm_clear;
    (bias_power_on == 6'h00) [*3] |-> !irq_warm;
  endproperty
  a_warm_clear: assert property (p_warm_clear)
    else $error("warm irq left with all bias off");
  property p_bias_src;
    $changed(bias_power_on) |-> $past(wr_done && paddr == 8'h10);
  endproperty
  a_bias_src: assert property (p_bias_src)
    else $error("bias enables moved without a write");
  property p_calib1_lock;
    $past(bias_power_on[1]) |-> $stable(calib_word[0]);
  endproperty
  a_calib1_lock: assert property (p_calib1_lock)
    else $error("calibration word 1 changed while powered");
  property p_calib7_lock;
    $past(bias_power_on[5]) |-> $stable(calib_word[4]);
  endproperty
  a_calib7_lock: assert property (p_calib7_lock)
    else $error("calibration word 7 changed while powered");
  property p_hi_en_read;
    pready && !pwrite && paddr == 8'h04 |-> prdata[31:12] == 20'h0_0000;
  endproperty
  a_hi_en_read: assert property (p_hi_en_read)
    else $error("upper enable bits read nonzero");
  property p_warm_irq;
    $rose(irq_warm) |-> $past(bias_power_on != 6'h00);
  endproperty
  a_warm_irq: assert property (p_warm_irq)
    else $error("warm irq rose with no converter powered");
endmodule // aew_ctrl_asserts

bind aew_ctrl aew_ctrl_asserts u_aew_ctrl_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_tick(conv_tick),
  .conv_active(conv_active), .conv_clk_left(conv_clk_left),
  .conv_input(conv_input), .early_select(early_select),
  .early_clr(early_clr), .present_boot(present_boot),
  .bias_power_on(bias_power_on), .calib_word(calib_word),
  .irq_early(irq_early), .irq_warm(irq_warm));
`default_nettype wire

// ---- test/test_adc_early_irq_and_warmup_ctrl.sv ----
// self-checking bench for the early-irq and warm-up register block
`timescale 1ns/1ns
`default_nettype none
module test_adc_early_irq_and_warmup_ctrl;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]       paddr, a;
  logic [31:0]      pwdata, prdata, seed, v, w;
  logic [5:0]       conv_tick, conv_active, bias_power_on;
  logic [5:0][3:0]  conv_clk_left;
  logic [5:0][5:0]  conv_input;
  logic [5:0][2:0]  early_select;
  logic [43:0]      early_clr, present_boot, st;
  logic [4:0][31:0] calib_word;
  logic             irq_early, irq_warm;
  logic [3:0]       cd;
  logic [33:0]      e;
  logic [33:0]      exp_q[$];
  int               err_total, checks_done, c, b;

  aew_ctrl u_aew_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_tick(conv_tick),
    .conv_active(conv_active), .conv_clk_left(conv_clk_left),
    .conv_input(conv_input), .early_select(early_select),
    .early_clr(early_clr), .present_boot(present_boot),
    .bias_power_on(bias_power_on), .calib_word(calib_word),
    .irq_early(irq_early), .irq_warm(irq_warm));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      err_total++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one transfer; the expected answer is noted before the request leaves
  task automatic apb(input logic wn, input logic [7:0] ad,
                     input logic [31:0] d, input logic [32:0] want);
    int k;
    exp_q.push_back({wn, want});
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wn;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      err_total++;
      close_out();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [31:0] want);
    apb(1'b0, ad, 32'h0000_0000, {1'b0, want});
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d, {1'b0, 32'h0000_0000});
  endtask

  // converter clock pulses; a real converter clock is not continuous here
  task automatic tick(input int cv, input int cnt);
    repeat (cnt) begin
      @(posedge pclk);
      conv_tick[cv] <= 1'b1;
      @(posedge pclk);
      conv_tick[cv] <= 1'b0;
    end
  endtask

  task automatic ev(input int cv, input logic [3:0] lft,
                    input logic [5:0] inp);
    @(posedge pclk);
    conv_active[cv]   <= 1'b1;
    conv_tick[cv]     <= 1'b1;
    conv_clk_left[cv] <= lft;
    conv_input[cv]    <= inp;
    @(posedge pclk);
    conv_active[cv] <= 1'b0;
    conv_tick[cv]   <= 1'b0;
  endtask

  // answer watcher: each completion is held against the oldest note
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h0000_0000, 32'h0000_0001);
      end else begin
        e = exp_q.pop_front();
        check({31'h0, pslverr}, {31'h0, e[32]});
        if (!e[33]) check(prdata, e[31:0]);
      end
    end
  end

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {conv_tick, conv_active, conv_clk_left, conv_input} = '0;
    {early_select, early_clr} = '0;
    seed = 32'ha16f_1156;
    v = rnd();
    present_boot = {v[11:0], rnd()};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, the boot map and an unmapped offset
    for (int i = 0; i < 10; i++) rd(8'(i * 4), 32'h0000_0000);
    rd(8'h28, present_boot[31:0]);
    rd(8'h2c, {20'h0_0000, present_boot[43:32]});
    apb(1'b0, 8'h30, 32'h0000_0000, {1'b1, 32'h0000_0000});
    v = rnd();
    wr(8'h00, v);
    rd(8'h00, v);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, 32'h0000_0fff);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0000);
    wr(8'h00, 32'h0000_0000);
    wr(8'h04, 32'h0000_0400);
    // every early_select code, each followed by a miss one clock early
    st = 44'h000_0000_0000;
    for (int k = 0; k < 8; k++) begin
      early_select[k % 6] <= 3'(k);
      ev(k % 6, 4'(k + 1), 6'(k * 6));
      ev(k % 6, 4'(k + 2), 6'(k * 6 + 1));
      st[k * 6] = 1'b1;
    end
    rd(8'h08, st[31:0]);
    rd(8'h0c, {20'h0_0000, st[43:32]});
    check({31'h0, irq_early}, 32'h0000_0001);
    wr(8'h04, 32'h0000_0000);
    repeat (2) @(negedge pclk);
    check({31'h0, irq_early}, 32'h0000_0000);
    // the clear pulse is launched on a rising edge like every other input
    @(posedge pclk);
    early_clr <= {44{1'b1}};
    @(posedge pclk);
    early_clr <= 44'h000_0000_0000;
    rd(8'h0c, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    // three warm-up lengths; early ticks while unpowered must not count
    for (int j = 0; j < 3; j++) begin
      c = (j == 0) ? 0 : (j == 1) ? 4 : 5;
      b = (c == 5) ? 7 : c;
      cd = 4'(3 + j + ((j > 0) ? 1 : 0));
      w = {4'h0, cd, 24'h00_0000} | (32'h1 << (b + 16)) | (32'h1 << b);
      tick(c, 3);
      wr(8'h10, w);
      tick(c, (1 << ((cd < 4'h4) ? 4 : int'(cd))) - 1);
      rd(8'h10, w);
      check({26'h0, bias_power_on}, 32'h1 << c);
      tick(c, 1);
      rd(8'h10, w | (32'h1 << (b + 8)));
      check({31'h0, irq_warm}, 32'h0000_0001);
      wr(8'h10, w & ~(32'h1 << b));
      rd(8'h10, w & ~(32'h1 << b));
      check({31'h0, irq_warm}, 32'h0000_0000);
      check({26'h0, bias_power_on}, 32'h0000_0000);
    end
    // calibration words take writes only while unpowered
    for (int k = 0; k < 5; k++) begin
      a = 8'h14 + 8'(k * 4);
      b = (k == 4) ? 7 : k + 1;
      v = rnd();
      wr(a, v);
      rd(a, v);
      check(calib_word[k], v);
      wr(8'h10, 32'h1 << b);
      wr(a, ~v);
      rd(a, v);
      check(calib_word[k], v);
      wr(8'h10, 32'h0000_0000);
    end
    close_out();
  end
endmodule // test_adc_early_irq_and_warmup_ctrl
`default_nettype wire
